/* File: tos_pkg.sv */
package tos_pkg;
   // register byte offsets
   localparam logic [7:0] TOS_GPO_CTRL_OFS   = 8'h00;
   localparam logic [7:0] TOS_AUX_CTRL_OFS   = 8'h04;
   localparam logic [7:0] TOS_FRAC_OFS       = 8'h08;
   localparam logic [7:0] TOS_TEST_OFS       = 8'h0C;
   localparam logic [7:0] TOS_STATUS_OFS     = 8'h10;
   // gpo control field positions
   localparam int         TOS_SEL_LSB        = 0;
   localparam int         TOS_DATA_LSB       = 4;
   // aux clock control field positions
   localparam int         TOS_AUX_SRC_LSB    = 0;
   localparam int         TOS_AUX_DLY_LSB    = 2;
   localparam int         TOS_AUX_DIV_LSB    = 4;
   // test register field positions
   localparam int         TOS_RING_TEST_BIT  = 0;
   // reset values
   localparam logic [31:0] TOS_GPO_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] TOS_AUX_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] TOS_FRAC_RST      = 32'h0000_0000;
   localparam logic [31:0] TOS_TEST_RST      = 32'h0000_0000;
   // axi response codes
   localparam logic [1:0] TOS_RESP_OKAY      = 2'h0;
   localparam logic [1:0] TOS_RESP_SLVERR    = 2'h2;
   // output source select codes
   typedef enum logic [3:0] {
      TOS_SEL_DIRECT = 4'h0,
      TOS_SEL_DIV    = 4'h1,
      TOS_SEL_LOCK   = 4'h2,
      TOS_SEL_SLIP   = 4'h3,
      TOS_SEL_FRAC   = 4'h4,
      TOS_SEL_ACC    = 4'h6,
      TOS_SEL_AUX    = 4'h7,
      TOS_SEL_MVCO   = 4'h9,
      TOS_SEL_MOD    = 4'hA
   } tos_sel_t;
   // aux source codes
   localparam logic [1:0] TOS_AUX_SRC_VCO    = 2'h0;
   localparam logic [1:0] TOS_AUX_SRC_REF    = 2'h1;
   localparam logic [1:0] TOS_AUX_SRC_RING   = 2'h2;
   // delay line length per delay step
   localparam int         TOS_DLY_STEP       = 2;
endpackage

/* File: tos_aux_clk.sv */
`timescale 1ns/1ns
// aux clock: source mux, delay line, even divider
module tos_aux_clk
   import tos_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_vco_clk,
   input  wire logic       i_ref_clk,
   input  wire logic       i_ring_clk,
   input  wire logic [1:0] i_src_sel,
   input  wire logic [1:0] i_dly_sel,
   input  wire logic [2:0] i_div_sel,
   output logic            o_aux_clk
);
   logic       src;
   logic [7:0] dly_reg, dly_next;
   logic       dly_tap, tap_reg;
   logic [3:0] cnt_reg, cnt_next;
   logic       out_reg, out_next;
   logic [3:0] half;

   // source pick; unstabilized ring is a free option
   always_comb begin
      case (i_src_sel)
         TOS_AUX_SRC_VCO:  src = i_vco_clk;
         TOS_AUX_SRC_REF:  src = i_ref_clk;
         TOS_AUX_SRC_RING: src = i_ring_clk;
         default:          src = i_vco_clk;
      endcase
   end

   // tapped delay line, tap chosen by delay mode
   always_comb begin
      dly_next = {dly_reg[6:0], src};
      case (i_dly_sel)
         2'h0:    dly_tap = src;
         2'h1:    dly_tap = dly_reg[TOS_DLY_STEP - 1];
         2'h2:    dly_tap = dly_reg[2 * TOS_DLY_STEP - 1];
         default: dly_tap = dly_reg[4 * TOS_DLY_STEP - 1];
      endcase
   end

   // divide by 2*(sel+1), counted on rising tap edges
   always_comb begin
      half     = {1'b0, i_div_sel} + 4'h1;
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (dly_tap && !tap_reg) begin                            // rising edge of the chosen tap
         if (cnt_reg + 4'h1 >= half) begin
            cnt_next = 4'h0;
            out_next = ~out_reg;
         end else begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dly_reg <= 8'h00;
         cnt_reg <= 4'h0;
         out_reg <= 1'b0;
         tap_reg <= 1'b0;
      end else begin
         dly_reg <= dly_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
         tap_reg <= dly_tap;
      end
   end

   assign o_aux_clk = out_reg;
endmodule // tos_aux_clk

/* File: tos_sync3.sv */
`timescale 1ns/1ns
// three-stage input sync; change taken once stages two and three agree
module tos_sync3 #(
   parameter int W = 1
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic [W-1:0]      o_q
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

   always_comb begin
      q_next = q_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            q_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end

   assign o_q = q_reg;
endmodule // tos_sync3

/* File: tos_output_selector.sv */
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
// What this block does
// - select 0 drives the three pins from direct value bits 6:4.
// - select 1 puts buffered reference input on pin 3.
// - select 1 puts reference divider on pin 2, prescaler on pin 1.
// - select 2: lock window pin 1, up pin 3, down pin 2.
// - select 3: ref-faster pin 3, vco-faster pin 2, max-gain hold pin 1.
// - max-gain hold stays asserted through pull-in until lock.
// - fractional register write makes a synchronized strobe starting modulator update.
// - select 4: frac strobe pin 1, reference divider pin 2, sine ref pin 3.
// - select 6: top three accumulator bits on pins 3..1, pin 3 msb.
// - select 7: aux clock pin 3, ring oscillator pin 2, modulator clock pin 1.
// - aux clock source from vco clocks, reference clocks or free ring.
// - aux clock delayed by amount set in bits 3:2 of aux control.
// - aux clock divided by even ratio 2 to 16 from bits 6:4.
// - select 10: three modulator output lsbs on pins 3..1, pin 1 lsb.
// - select 9: multi-vco latch enables on the pins.
// - ring test mode with select 7: lock ring on pin 2, lock detect off.
module tos_output_selector
   import tos_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   // axi4-lite slave
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // internal waveforms from pins or other clock trees
   input  wire logic        i_ref_in,
   input  wire logic        i_sine_ref,
   input  wire logic        i_ref_div,
   input  wire logic        i_prescaler,
   input  wire logic        i_pfd_up,
   input  wire logic        i_pfd_dn,
   input  wire logic        i_ref_faster,
   input  wire logic        i_vco_faster,
   input  wire logic        i_vco_clk,
   input  wire logic        i_ring_osc,
   input  wire logic        i_lock_ring,
   input  wire logic        i_lock_window,
   input  wire logic        i_locked,
   // modulator state, same clock
   input  wire logic [2:0]  i_acc_msb,
   input  wire logic [2:0]  i_mod_lsb,
   input  wire logic        i_mod_clk,
   input  wire logic [2:0]  i_mvco_le,
   // outputs
   output logic             o_frac_update,
   output logic [31:0]      o_frac_word,
   output logic             o_lock_detect_en,
   output logic             o_aux_out_pin1,
   output logic             o_aux_out_pin2,
   output logic             o_aux_out_pin3
);
   localparam int NS = 13;

   logic [31:0]   gpo_ctrl_reg, gpo_ctrl_next;
   logic [31:0]   aux_ctrl_reg, aux_ctrl_next;
   logic [31:0]   frac_reg, frac_next;
   logic [31:0]   test_reg, test_next;
   logic          aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
   logic [7:0]    awa_reg, awa_next;
   logic [31:0]   wd_reg, wd_next;
   logic [3:0]    ws_reg, ws_next;
   logic [1:0]    bresp_reg, bresp_next;
   logic          r_reg, r_next;
   logic [31:0]   rdata_reg, rdata_next;
   logic [1:0]    rresp_reg, rresp_next;
   logic          frac_wr_reg, frac_wr_next;
   logic          strobe_reg, strobe_next;
   logic          hold_reg, hold_next;
   logic [2:0]    pins_reg, pins_next;
   logic [NS-1:0] raw, syn;
   logic          aux_clk;
   logic          ring_test;
   logic          do_write;

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // known offsets
   function automatic logic mapped(input logic [7:0] a);
      return (a == TOS_GPO_CTRL_OFS) || (a == TOS_AUX_CTRL_OFS) || (a == TOS_FRAC_OFS)
             || (a == TOS_TEST_OFS) || (a == TOS_STATUS_OFS);
   endfunction

   // pin and foreign-clock signals resynchronized before use
   assign raw = {i_ref_in, i_sine_ref, i_ref_div, i_prescaler, i_pfd_up, i_pfd_dn,
                 i_ref_faster, i_vco_faster, i_vco_clk, i_ring_osc, i_lock_ring,
                 i_lock_window, i_locked};

   tos_sync3 #(.W(NS)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_d       (raw),
      .o_q       (syn)
   );

   // aux clock generator
   tos_aux_clk u_aux (
      .i_sys_clk  (i_sys_clk),
      .i_rst_n    (i_rst_n),
      .i_vco_clk  (syn[4]),
      .i_ref_clk  (syn[12]),
      .i_ring_clk (syn[3]),
      .i_src_sel  (aux_ctrl_reg[TOS_AUX_SRC_LSB +: 2]),
      .i_dly_sel  (aux_ctrl_reg[TOS_AUX_DLY_LSB +: 2]),
      .i_div_sel  (aux_ctrl_reg[TOS_AUX_DIV_LSB +: 3]),
      .o_aux_clk  (aux_clk)
   );

   assign do_write = aw_reg && w_reg && !b_reg;

   // write channel: address and data taken in either order, response after both
   always_comb begin
      aw_next       = aw_reg;
      w_next        = w_reg;
      b_next        = b_reg;
      awa_next      = awa_reg;
      wd_next       = wd_reg;
      ws_next       = ws_reg;
      bresp_next    = bresp_reg;
      gpo_ctrl_next = gpo_ctrl_reg;
      aux_ctrl_next = aux_ctrl_reg;
      frac_next     = frac_reg;
      test_next     = test_reg;
      frac_wr_next  = 1'b0;
      if (i_awvalid && o_awready) begin
         aw_next  = 1'b1;
         awa_next = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         w_next  = 1'b1;
         wd_next = i_wdata;
         ws_next = i_wstrb;
      end
      if (do_write) begin
         b_next     = 1'b1;
         bresp_next = mapped(awa_reg) ? TOS_RESP_OKAY : TOS_RESP_SLVERR;
         case (awa_reg)
            TOS_GPO_CTRL_OFS: gpo_ctrl_next = merge(gpo_ctrl_reg, wd_reg, ws_reg);
            TOS_AUX_CTRL_OFS: aux_ctrl_next = merge(aux_ctrl_reg, wd_reg, ws_reg);
            TOS_FRAC_OFS: begin
               frac_next    = merge(frac_reg, wd_reg, ws_reg);
               frac_wr_next = 1'b1;
            end
            TOS_TEST_OFS:     test_next = merge(test_reg, wd_reg, ws_reg);
            default:          ;
         endcase
      end
      if (b_reg && i_bready) begin
         b_next  = 1'b0;
         aw_next = 1'b0;
         w_next  = 1'b0;
      end
   end

   assign o_awready = !aw_reg;
   assign o_wready  = !w_reg;
   assign o_bvalid  = b_reg;
   assign o_bresp   = bresp_reg;

   // read channel: one cycle to answer, held until rready
   always_comb begin
      r_next     = r_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (i_arvalid && o_arready) begin
         r_next     = 1'b1;
         rresp_next = mapped(i_araddr) ? TOS_RESP_OKAY : TOS_RESP_SLVERR;
         case (i_araddr)
            TOS_GPO_CTRL_OFS: rdata_next = gpo_ctrl_reg;
            TOS_AUX_CTRL_OFS: rdata_next = aux_ctrl_reg;
            TOS_FRAC_OFS:     rdata_next = frac_reg;
            TOS_TEST_OFS:     rdata_next = test_reg;
            TOS_STATUS_OFS:   rdata_next = {27'h0, hold_reg, o_lock_detect_en, pins_reg};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end else if (r_reg && i_rready) begin
         r_next = 1'b0;
      end
   end

   assign o_arready = !r_reg;
   assign o_rvalid  = r_reg;
   assign o_rdata   = rdata_reg;
   assign o_rresp   = rresp_reg;

   // ring test mode gates lock detection off
   assign ring_test        = test_reg[TOS_RING_TEST_BIT];
   assign o_lock_detect_en = !ring_test;

   // frac strobe one cycle after the write lands; max-gain hold until lock
   always_comb begin
      strobe_next = frac_wr_reg;
      if (!syn[0]) begin
         hold_next = syn[6] | syn[5];
         if (hold_reg) begin
            hold_next = 1'b1;
         end
      end else begin
         hold_next = 1'b0;
      end
   end

   // output mux, registered so pins never glitch on select change
   always_comb begin
      case (gpo_ctrl_reg[TOS_SEL_LSB +: 4])
         TOS_SEL_DIRECT: pins_next = gpo_ctrl_reg[TOS_DATA_LSB +: 3];
         TOS_SEL_DIV:    pins_next = {syn[12], syn[10], syn[9]};
         TOS_SEL_LOCK:   pins_next = {syn[8], syn[7], syn[1]};
         TOS_SEL_SLIP:   pins_next = {syn[6], syn[5], hold_reg};
         TOS_SEL_FRAC:   pins_next = {syn[11], syn[10], strobe_reg};
         TOS_SEL_ACC:    pins_next = i_acc_msb;
         TOS_SEL_AUX:    pins_next = {aux_clk, ring_test ? syn[2] : syn[3],
                                      i_mod_clk};
         TOS_SEL_MVCO:   pins_next = i_mvco_le;
         TOS_SEL_MOD:    pins_next = i_mod_lsb;
         default:        pins_next = 3'h0;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gpo_ctrl_reg <= TOS_GPO_CTRL_RST;
         aux_ctrl_reg <= TOS_AUX_CTRL_RST;
         frac_reg     <= TOS_FRAC_RST;
         test_reg     <= TOS_TEST_RST;
         aw_reg       <= 1'b0;
         w_reg        <= 1'b0;
         b_reg        <= 1'b0;
         awa_reg      <= 8'h00;
         wd_reg       <= 32'h0000_0000;
         ws_reg       <= 4'h0;
         bresp_reg    <= 2'h0;
         r_reg        <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= 2'h0;
         frac_wr_reg  <= 1'b0;
         strobe_reg   <= 1'b0;
         hold_reg     <= 1'b0;
         pins_reg     <= 3'h0;
      end else begin
         gpo_ctrl_reg <= gpo_ctrl_next;
         aux_ctrl_reg <= aux_ctrl_next;
         frac_reg     <= frac_next;
         test_reg     <= test_next;
         aw_reg       <= aw_next;
         w_reg        <= w_next;
         b_reg        <= b_next;
         awa_reg      <= awa_next;
         wd_reg       <= wd_next;
         ws_reg       <= ws_next;
         bresp_reg    <= bresp_next;
         r_reg        <= r_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
         frac_wr_reg  <= frac_wr_next;
         strobe_reg   <= strobe_next;
         hold_reg     <= hold_next;
         pins_reg     <= pins_next;
      end
   end

   assign o_frac_update  = strobe_reg;
   assign o_frac_word    = frac_reg;
   assign o_aux_out_pin1 = pins_reg[0];
   assign o_aux_out_pin2 = pins_reg[1];
   assign o_aux_out_pin3 = pins_reg[2];
endmodule // tos_output_selector

/* File: tos_output_selector_props.sv */
`timescale 1ns/1ns
// pin checker; select field shadowed from the write channel
module tos_output_selector_props
   import tos_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   input  wire logic        o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   input  wire logic        o_wready,
   input  wire logic [2:0]  i_acc_msb,
   input  wire logic [2:0]  i_mod_lsb,
   input  wire logic        i_mod_clk,
   input  wire logic [2:0]  i_mvco_le,
   input  wire logic        o_frac_update,
   input  wire logic [31:0] o_frac_word,
   input  wire logic        o_aux_out_pin1,
   input  wire logic        o_aux_out_pin2,
   input  wire logic        o_aux_out_pin3
);
   logic       wr_hs;
   logic [3:0] sel_reg, sel_next;
   logic [2:0] dat_reg, dat_next;
   logic [1:0] quiet_reg, quiet_next;
   logic [2:0] pins;
   // quiet counter covers the register and pin stages
   always_comb begin
      wr_hs = i_awvalid && o_awready && i_wvalid && o_wready;
      sel_next = sel_reg;
      dat_next = dat_reg;
      quiet_next = (quiet_reg == 2'h3) ? quiet_reg : quiet_reg + 2'h1;
      if (wr_hs && i_awaddr == TOS_GPO_CTRL_OFS) begin
         sel_next = i_wdata[3:0];
         dat_next = i_wdata[6:4];
         quiet_next = 2'h0;
      end
   end
   // shadow registers
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_reg <= 4'h0;
         dat_reg <= 3'h0;
         quiet_reg <= 2'h3;
      end else begin
         sel_reg <= sel_next;
         dat_reg <= dat_next;
         quiet_reg <= quiet_next;
      end
   end
   assign pins = {o_aux_out_pin3, o_aux_out_pin2, o_aux_out_pin1};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_direct_value: assert property (quiet_reg == 2'h3 && sel_reg == 4'h0 |-> pins == dat_reg)
      else $error("pins differ from direct value");
   a_acc_msb: assert property (quiet_reg == 2'h3 && sel_reg == 4'h6 |-> pins == $past(i_acc_msb))
      else $error("accumulator bits wrong on pins");
   a_mvco_latch: assert property (quiet_reg == 2'h3 && sel_reg == 4'h9 |-> pins == $past(i_mvco_le))
      else $error("latch enables wrong on pins");
   a_mod_lsb: assert property (quiet_reg == 2'h3 && sel_reg == 4'hA |-> pins == $past(i_mod_lsb))
      else $error("modulator bits wrong on pins");
   a_unused_low: assert property (quiet_reg == 2'h3 && sel_reg inside {4'h5, 4'h8, [4'hB:4'hF]} |-> pins == 3'h0)
      else $error("unassigned select not low");
   a_mod_clock: assert property (quiet_reg == 2'h3 && sel_reg == 4'h7 |-> o_aux_out_pin1 == $past(i_mod_clk))
      else $error("modulator clock missing on pin1");
   a_frac_strobe: assert property (wr_hs && i_awaddr == TOS_FRAC_OFS && i_wstrb == 4'hF
      |-> ##3 (o_frac_update && o_frac_word == $past(i_wdata, 3)) ##1 !o_frac_update)
      else $error("frac strobe or word wrong");
   a_frac_pin: assert property (quiet_reg == 2'h3 && sel_reg == 4'h4 |-> o_aux_out_pin1 == $past(o_frac_update))
      else $error("frac strobe missing on pin1");
endmodule // tos_output_selector_props

bind tos_output_selector tos_output_selector_props i_tos_output_selector_props (.i_sys_clk, .i_rst_n,
   .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .i_acc_msb, .i_mod_lsb,
   .i_mod_clk, .i_mvco_le, .o_frac_update, .o_frac_word, .o_aux_out_pin1, .o_aux_out_pin2, .o_aux_out_pin3);

/* File: tos_pin_watch.sv */
`timescale 1ns/1ns
// far-side observer: counts rising edges seen on pins 1 and 3
module tos_pin_watch (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_clear,
   input  wire logic        i_pin1,
   input  wire logic        i_pin3,
   output logic [15:0]      o_rise1,
   output logic [15:0]      o_rise3
);
   logic [1:0]  last_reg, last_next;
   logic [15:0] r1_next, r3_next;
   // pins are registered, so sampling on the system clock sees every edge
   always_comb begin
      last_next = {i_pin3, i_pin1};
      r1_next = i_clear ? 16'h0000 : o_rise1 + {15'h0000, i_pin1 & ~last_reg[0]};
      r3_next = i_clear ? 16'h0000 : o_rise3 + {15'h0000, i_pin3 & ~last_reg[1]};
   end
   // counters
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_reg <= 2'h0;
         o_rise1 <= 16'h0000;
         o_rise3 <= 16'h0000;
      end else begin
         last_reg <= last_next;
         o_rise1 <= r1_next;
         o_rise3 <= r3_next;
      end
   end
endmodule // tos_pin_watch

/* File: tos_output_selector_test.sv */
`timescale 1ns/1ns
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("FAIL %0t %s", $time, m); end end
module tos_output_selector_test
   import tos_pkg::*;
   ;
   logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0, i_mod_clk = 1'b0, ref_tog = 1'b0, clr = 1'b0;
   logic        gen_run = 1'b1, run_ref = 1'b0;
   logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic [3:0]  i_wstrb = 4'hF;
   logic [12:0] src = 13'h0000;
   logic [2:0]  i_acc_msb = 3'h0, i_mod_lsb = 3'h0, i_mvco_le = 3'h0, pins;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_frac_update, o_lock_detect_en;
   logic        o_aux_out_pin1, o_aux_out_pin2, o_aux_out_pin3;
   logic [1:0]  o_bresp, o_rresp;
   logic [31:0] o_rdata, o_frac_word;
   logic [15:0] rise1, rise3;
   int          errors = 0, samples_checked = 0, rcnt = 0, fcnt = 0;
   // entries {select, pin, source bit}
   logic [11:0] tab [11] = '{12'h130, 12'h122, 12'h113, 12'h21B, 12'h234, 12'h225, 12'h336, 12'h327,
                             12'h422, 12'h431, 12'h729};
   // entries {expected rises, div, delay, source}
   logic [15:0] atab [4] = '{16'h3201, 16'h076D, 16'h1025, 16'h0000};
   assign pins = {o_aux_out_pin3, o_aux_out_pin2, o_aux_out_pin1};
   tos_output_selector i_tos_output_selector (.i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
      .o_rresp, .o_rvalid, .i_rready, .i_ref_in(src[0] ^ ref_tog), .i_sine_ref(src[1]), .i_ref_div(src[2]),
      .i_prescaler(src[3]), .i_pfd_up(src[4]), .i_pfd_dn(src[5]), .i_ref_faster(src[6]), .i_vco_faster(src[7]),
      .i_vco_clk(src[8]), .i_ring_osc(src[9]), .i_lock_ring(src[10]), .i_lock_window(src[11]),
      .i_locked(src[12]), .i_acc_msb, .i_mod_lsb, .i_mod_clk, .i_mvco_le, .o_frac_update, .o_frac_word,
      .o_lock_detect_en, .o_aux_out_pin1, .o_aux_out_pin2, .o_aux_out_pin3);
   tos_pin_watch i_tos_pin_watch (.i_sys_clk, .i_rst_n, .i_clear(clr), .i_pin1(o_aux_out_pin1),
      .i_pin3(o_aux_out_pin3), .o_rise1(rise1), .o_rise3(rise3));
   always #50 i_sys_clk = ~i_sys_clk;
   // free-running modulator sources, slow reference
   always @(posedge i_sys_clk) begin
      if (gen_run) begin
         i_acc_msb <= i_acc_msb + 3'h1;
         i_mod_lsb <= i_mod_lsb - 3'h1;
         i_mvco_le <= i_mvco_le + 3'h3;
         i_mod_clk <= ~i_mod_clk;
      end
      if (run_ref) begin
         rcnt <= (rcnt == 2) ? 0 : rcnt + 1;
         if (rcnt == 2) ref_tog <= ~ref_tog;
      end
      if (o_frac_update) fcnt <= fcnt + 1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
   endtask
   task automatic put(input logic [12:0] v);
      @(posedge i_sys_clk);
      src <= v;
      cyc(8);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = TOS_RESP_OKAY);
      logic aw_d, w_d, ha, hw;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge i_sys_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(negedge i_sys_clk);
         ha = i_awvalid && o_awready;
         hw = i_wvalid && o_wready;
         @(posedge i_sys_clk);
         if (ha) begin
            i_awvalid <= 1'b0;
            aw_d = 1'b1;
         end
         if (hw) begin
            i_wvalid <= 1'b0;
            w_d = 1'b1;
         end
      end
      i_bready <= 1'b1;
      do @(negedge i_sys_clk); while (!o_bvalid);
      `CHK(o_bresp, er, "write response")
      @(posedge i_sys_clk);
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = TOS_RESP_OKAY);
      @(posedge i_sys_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(negedge i_sys_clk); while (!o_arready);
      @(posedge i_sys_clk);
      i_arvalid <= 1'b0;
      do @(negedge i_sys_clk); while (!o_rvalid);
      `CHK(o_rdata, ed, "read data")
      `CHK(o_rresp, er, "read response")
      @(posedge i_sys_clk);
      i_rready <= 1'b0;
   endtask
   task automatic t_regs;
      rd(TOS_GPO_CTRL_OFS, TOS_GPO_CTRL_RST);
      rd(TOS_AUX_CTRL_OFS, TOS_AUX_CTRL_RST);
      rd(TOS_FRAC_OFS, TOS_FRAC_RST);
      rd(TOS_TEST_OFS, TOS_TEST_RST);
      rd(TOS_STATUS_OFS, 32'h0000_0008);
      rd(8'h14, 32'h0000_0000, TOS_RESP_SLVERR);
      wr(8'h14, 32'hFFFF_FFFF, TOS_RESP_SLVERR);
      wr(TOS_STATUS_OFS, 32'hFFFF_FFFF);
      rd(TOS_STATUS_OFS, 32'h0000_0008);
   endtask
   task automatic t_direct;
      for (int v = 7; v >= 0; v--) begin
         wr(TOS_GPO_CTRL_OFS, {25'h0, v[2:0], 4'h0});
         cyc(3);
         `CHK(pins, v[2:0], "direct value")
      end
   endtask
   // each source raised alone, then dropped
   task automatic t_table;
      int p;
      for (int i = 0; i < 11; i++) begin
         p = tab[i][5:4];
         wr(TOS_GPO_CTRL_OFS, {28'h0, tab[i][11:8]});
         put(13'h0001 << tab[i][3:0]);
         `CHK(pins[p-1], 1'b1, "routed source high")
         put(13'h0000);
         `CHK(pins[p-1], 1'b0, "routed source low")
      end
   endtask
   task automatic t_hold;
      wr(TOS_GPO_CTRL_OFS, 32'h0000_0003);
      put(13'h1000);
      `CHK(o_aux_out_pin1, 1'b0, "hold while locked")
      put(13'h0040);
      put(13'h0000);
      `CHK(o_aux_out_pin1, 1'b1, "hold through pull-in")
      rd(TOS_STATUS_OFS, 32'h0000_0019);
      put(13'h1000);
      `CHK(o_aux_out_pin1, 1'b0, "hold released at lock")
      put(13'h0000);
   endtask
   task automatic t_gen;
      logic [2:0] e;
      @(posedge i_sys_clk);
      gen_run <= 1'b0;
      @(posedge i_sys_clk);
      i_acc_msb <= 3'h5;
      i_mod_lsb <= 3'h3;
      i_mvco_le <= 3'h6;
      i_mod_clk <= 1'b1;
      for (int s = 5; s < 16; s++) begin
         wr(TOS_GPO_CTRL_OFS, s);
         cyc(3);
         e = (s == 6) ? 3'h5 : (s == 9) ? 3'h6 : (s == 10) ? 3'h3 : 3'h0;
         if (s == 7) `CHK(o_aux_out_pin1, 1'b1, "modulator clock")
         else `CHK(pins, e, "modulator or unused select")
      end
   endtask
   task automatic t_frac;
      int f0;
      wr(TOS_GPO_CTRL_OFS, 32'h0000_0004);
      @(posedge i_sys_clk);
      clr <= 1'b1;
      @(posedge i_sys_clk);
      clr <= 1'b0;
      f0 = fcnt;
      wr(TOS_FRAC_OFS, 32'h89AB_CDEF);
      cyc(6);
      `CHK(o_frac_word, 32'h89AB_CDEF, "frac word")
      `CHK(fcnt - f0, 1, "one frac strobe")
      `CHK(rise1, 16'h0001, "frac strobe on pin1")
      rd(TOS_FRAC_OFS, 32'h89AB_CDEF);
   endtask
   task automatic t_ring;
      wr(TOS_TEST_OFS, 32'h0000_0001);
      wr(TOS_GPO_CTRL_OFS, 32'h0000_0007);
      put(13'h0400);
      `CHK(o_lock_detect_en, 1'b0, "lock detect off in test")
      `CHK(o_aux_out_pin2, 1'b1, "lock ring on pin2")
      wr(TOS_TEST_OFS, 32'h0000_0000);
      put(13'h0000);
      `CHK(o_lock_detect_en, 1'b1, "lock detect back on")
   endtask
   // aux clock rises on pin3 over 100 reference periods
   task automatic t_aux;
      int x;
      @(posedge i_sys_clk);
      run_ref <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(TOS_AUX_CTRL_OFS, {25'h0, atab[i][6:0]});
         cyc(20);
         @(posedge i_sys_clk);
         clr <= 1'b1;
         @(posedge i_sys_clk);
         clr <= 1'b0;
         cyc(599);
         x = rise3 - atab[i][15:8];
         `CHK(x >= -1 && x <= 1, 1'b1, "aux clock rate")
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well past the planned run
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      errors++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_direct();
      t_table();
      t_hold();
      t_gen();
      t_frac();
      t_ring();
      t_aux();
      conclude();
   end
endmodule // tos_output_selector_test
